//--- src/ms_tick.sv
// One-cycle pulse every millisecond
`default_nettype none
module ms_tick #(
  parameter int CYCLES = 125000
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [31:0] cnt_q;
  wire         wrap = (cnt_q == 32'(CYCLES - 1));

  always_ff @(posedge clock_i) begin
    if (rst_i || wrap) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= wrap;
    end
  end
endmodule
`default_nettype wire

//--- src/pse_host_ctrl.sv
// Host end: command issue, event service and timed power grants
`default_nettype none
module pse_host_ctrl
  import pse_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  pse_link_if.host         link,
  input  wire logic        user_cmd_valid_i,
  input  wire logic [3:0]  user_code_i,
  input  wire logic [1:0]  user_port_i,
  output logic             user_ready_o,
  input  wire logic        user_thr_valid_i,
  input  wire logic [1:0]  user_thr_port_i,
  input  wire logic [7:0]  user_thr_val_i,
  input  wire logic [3:0]  grant_i,
  output logic             user_resp_valid_o,
  output logic [15:0]      user_resp_data_o,
  output logic [7:0]       events_o,
  output logic [3:0]       grant_miss_o
);

  function automatic logic [1:0] low_idx(input logic [3:0] v);
    if (v[0]) begin
      return 2'd0;
    end else if (v[1]) begin
      return 2'd1;
    end else if (v[2]) begin
      return 2'd2;
    end else begin
      return 2'd3;
    end
  endfunction

  localparam logic [7:0] T_GRANT = 8'(GRANT_MS);

  host_state_e st_q;
  logic [3:0]  todo_q;
  logic [7:0]  left_q;
  logic        tick;
  logic        cmd_valid_q;
  logic [7:0]  cmd_byte_q;
  logic        evt_rd_q;
  logic        thr_wr_q;
  logic [1:0]  thr_port_q;
  logic [7:0]  thr_val_q;

  ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_o  (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Service

  // Pending interrupts pre-empt user commands so grants meet the deadline
  assign user_ready_o = (st_q == HS_IDLE) && !link.int_req;
  wire   user_go      = user_cmd_valid_i && user_ready_o;
  wire   late         = (left_q == 8'h00);
  wire [1:0] gidx     = low_idx(todo_q);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q         <= HS_IDLE;
      todo_q       <= 4'h0;
      left_q       <= 8'h00;
      events_o     <= 8'h00;
      grant_miss_o <= 4'h0;
      cmd_valid_q  <= 1'b0;
      cmd_byte_q   <= 8'h00;
      evt_rd_q     <= 1'b0;
    end else begin
      cmd_valid_q <= 1'b0;
      evt_rd_q    <= 1'b0;
      if (tick && !late) begin
        left_q <= left_q - 8'h01;
      end
      case (st_q)
        HS_IDLE: begin
          if (link.int_req) begin
            evt_rd_q <= 1'b1;
            st_q     <= HS_READ;
          end else if (user_go) begin
            cmd_valid_q <= 1'b1;
            cmd_byte_q  <= {2'b00, user_code_i, user_port_i};
          end
        end
        HS_READ: begin
          if (link.resp_valid) begin
            events_o <= link.resp_data[7:0];
            todo_q   <= link.resp_data[3:0] & grant_i;
            left_q   <= T_GRANT;
            st_q     <= HS_GRANT;
          end else if (!evt_rd_q) begin
            // Reply lost to a chip reset: give up rather than hang
            st_q <= HS_IDLE;
          end
        end
        HS_GRANT: begin
          if (todo_q == 4'h0) begin
            st_q <= HS_IDLE;
          end else if (late) begin
            grant_miss_o <= grant_miss_o | todo_q;
            todo_q       <= 4'h0;
            st_q         <= HS_IDLE;
          end else begin
            cmd_valid_q    <= 1'b1;
            cmd_byte_q     <= {2'b00, CMD_POWER_ON, gidx};
            todo_q[gidx]   <= 1'b0;
          end
        end
        default: begin
          st_q <= HS_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Threshold writes and user responses

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      thr_wr_q          <= 1'b0;
      thr_port_q        <= 2'd0;
      thr_val_q         <= 8'h00;
      user_resp_valid_o <= 1'b0;
      user_resp_data_o  <= 16'h0000;
    end else begin
      thr_wr_q          <= user_thr_valid_i;
      thr_port_q        <= user_thr_port_i;
      thr_val_q         <= user_thr_val_i;
      user_resp_valid_o <= link.resp_valid && (st_q == HS_IDLE);
      if (link.resp_valid) begin
        user_resp_data_o <= link.resp_data;
      end
    end
  end

  assign link.cmd_valid = cmd_valid_q;
  assign link.cmd_byte  = cmd_byte_q;
  assign link.evt_rd    = evt_rd_q;
  assign link.thr_wr    = thr_wr_q;
  assign link.thr_port  = thr_port_q;
  assign link.thr_val   = thr_val_q;
endmodule
`default_nettype wire

//--- src/pse_link_if.sv
// Command link between host and port controller
`default_nettype none
interface pse_link_if;
  logic        cmd_valid;
  logic [7:0]  cmd_byte;
  logic        thr_wr;
  logic [1:0]  thr_port;
  logic [7:0]  thr_val;
  logic        evt_rd;
  logic        resp_valid;
  logic [15:0] resp_data;
  logic        int_req;

  modport dev (
    input  cmd_valid, cmd_byte, thr_wr, thr_port, thr_val, evt_rd,
    output resp_valid, resp_data, int_req
  );
  modport host (
    output cmd_valid, cmd_byte, thr_wr, thr_port, thr_val, evt_rd,
    input  resp_valid, resp_data, int_req
  );
endinterface
`default_nettype wire

//--- src/pse_pkg.sv
// Shared constants and types for the port command and turn-on logic
`default_nettype none
package pse_pkg;
  localparam int          PORTS          = 4;
  localparam int          CLOCK_HZ       = 125_000_000;
  localparam int          MS_PER_S       = 1000;
  localparam int          MS_CYCLES_DEF  = CLOCK_HZ / MS_PER_S;
  // Times in ms (BACKOFF_S in s), counted with a 1 ms tick
  localparam int          TSTART_MS      = 60;
  localparam int          BACKOFF_S      = 2;
  localparam int          BACKOFF_MS     = BACKOFF_S * MS_PER_S;
  localparam int          DET_RETRY_MS   = 1;
  localparam int          GRANT_MS       = 250;
  localparam int          MS_W           = 11;
  // Command codes, bits 5..2 of the command byte
  localparam logic [3:0]  CMD_POWER_ON   = 4'h1;
  localparam logic [3:0]  CMD_POWER_OFF  = 4'h2;
  localparam logic [3:0]  CMD_PORT_RST   = 4'h3;
  localparam logic [3:0]  CMD_TOGGLE_BO  = 4'h4;
  localparam logic [3:0]  CMD_CHIP_RST   = 4'h5;
  localparam logic [3:0]  CMD_GET_VEE    = 4'h6;
  localparam logic [3:0]  CMD_GET_CUR    = 4'h7;
  localparam logic [3:0]  CMD_SHED_LOW   = 4'h8;
  localparam int          CODE_LSB       = 2;
  // Port operating modes
  localparam logic [1:0]  MODE_SHUTDOWN  = 2'h0;
  localparam logic [1:0]  MODE_MANUAL    = 2'h1;
  localparam logic [1:0]  MODE_SEMI      = 2'h2;
  localparam logic [1:0]  MODE_AUTO      = 2'h3;
  // Class result encodings
  localparam logic [2:0]  CLS_1          = 3'h1;
  localparam logic [2:0]  CLS_2          = 3'h2;
  localparam logic [2:0]  CLS_3          = 3'h3;
  localparam logic [2:0]  CLS_4          = 3'h4;
  localparam logic [2:0]  CLS_0          = 3'h6;
  // Overcurrent cut threshold settings
  localparam logic [7:0]  CUT_CLASS1     = 8'h1E;
  localparam logic [7:0]  CUT_CLASS2     = 8'h35;
  localparam logic [7:0]  CUT_DEFAULT    = 8'h75;
  localparam logic [7:0]  CUT_CLASS4_HP  = 8'hC9;
  localparam logic [7:0]  CUT_START      = 8'h75;

  typedef enum logic [2:0] {
    PS_IDLE,
    PS_DET,
    PS_CLS,
    PS_START,
    PS_ON
  } port_state_e;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_READ,
    HS_GRANT
  } host_state_e;
endpackage
`default_nettype wire

//--- src/pse_port_ctrl.sv
// Port controller end: command decode and per-port turn-on sequencing
//
// Function
// - Auto mode loads cut threshold from class
// - Limit held 1x during start window
// - Port index in low bits; on/off/reset codes
// - Toggle midspan bit; two-second detect back-off
// - Port current read returns two bytes
// - Supply voltage read returns two bytes
// - Shed low-priority ports; whole-chip reset
// - Auto mode self-sequenced; second class event
// - Semi-auto power-on waits for valid results
// - No auto threshold in semi/manual; two-event class
// - Manual power-on skips detect, always powers
// - Manual power-on class sets no flag
// - Host powers within 250 ms of class flag
// - Start window 375 mA cut, then power-good
// - After start, 2x limit if high power
// - Host may overwrite threshold after power-good
// - Interrupt register and pin within 5 ms
// - Host clears events by clear-on-read read
// - Measurements sampled when command is written
// - Two-bit port mode: shutdown/manual/semi/auto
`default_nettype none
module pse_port_ctrl
  import pse_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  pse_link_if.dev            link,
  input  wire logic [7:0]    port_mode_i,
  input  wire logic [3:0]    hp_enable_i,
  input  wire logic [3:0]    low_prio_i,
  input  wire logic [7:0]    int_mask_i,
  input  wire logic [3:0]    det_done_i,
  input  wire logic [3:0]    det_good_i,
  input  wire logic [3:0]    class_done_i,
  input  wire logic [11:0]   class_result_i,
  input  wire logic [3:0]    overload_i,
  input  wire logic [63:0]   port_current_i,
  input  wire logic [15:0]   vee_mv_i,
  output logic      [3:0]    det_req_o,
  output logic      [3:0]    class_req_o,
  output logic      [3:0]    power_en_o,
  output logic      [3:0]    pgood_o,
  output logic      [3:0]    limit_2x_o,
  output logic      [31:0]   cut_thr_o,
  output logic               midspan_o
);

  function automatic logic [7:0] class_cut(input logic [2:0] c,
                                           input logic       hp);
    if (c == CLS_1) begin
      return CUT_CLASS1;
    end else if (c == CLS_2) begin
      return CUT_CLASS2;
    end else if (c == CLS_4 && hp) begin
      return CUT_CLASS4_HP;
    end else begin
      return CUT_DEFAULT;
    end
  endfunction

  function automatic logic class_ok(input logic [2:0] c);
    return (c == CLS_0) || (c == CLS_1) || (c == CLS_2) ||
           (c == CLS_3) || (c == CLS_4);
  endfunction

  localparam logic [MS_W-1:0] T_START = MS_W'(TSTART_MS);
  localparam logic [MS_W-1:0] T_BACK  = MS_W'(BACKOFF_MS);
  localparam logic [MS_W-1:0] T_RETRY = MS_W'(DET_RETRY_MS);

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  logic            tick;
  logic            soft_rst_q;
  logic            midspan_q;
  logic [7:0]      evt_q;
  logic            int_q;
  logic            resp_valid_q;
  logic [15:0]     resp_data_q;

  // Soft reset lands one cycle after the command, clearing all ports
  wire       srst     = rst_i || soft_rst_q;
  wire [3:0] code     = link.cmd_byte[5:CODE_LSB];
  wire [1:0] prm      = link.cmd_byte[1:0];
  wire       fire     = link.cmd_valid;
  wire       is_on    = fire && (code == CMD_POWER_ON);
  wire       is_off   = fire && (code == CMD_POWER_OFF);
  wire       is_prst  = fire && (code == CMD_PORT_RST);
  wire       is_tog   = fire && (code == CMD_TOGGLE_BO);
  wire       is_crst  = fire && (code == CMD_CHIP_RST);
  wire       is_vee   = fire && (code == CMD_GET_VEE);
  wire       is_cur   = fire && (code == CMD_GET_CUR);
  wire       is_shed  = fire && (code == CMD_SHED_LOW);
  wire [MS_W-1:0] gap = midspan_q ? T_BACK : T_RETRY;

  ms_tick #(
    .CYCLES (MS_CYCLES)
  ) u_tick (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .tick_o  (tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Per-port sequencers

  port_state_e     st_q   [PORTS];
  port_state_e     st_d   [PORTS];
  logic [MS_W-1:0] cnt_q  [PORTS];
  logic [MS_W-1:0] cnt_d  [PORTS];
  logic [7:0]      cut_q  [PORTS];
  logic [7:0]      cut_d  [PORTS];
  logic [3:0]      pend_q;
  logic [3:0]      pend_d;
  logic [3:0]      man_q;
  logic [3:0]      man_d;
  logic [3:0]      two_q;
  logic [3:0]      two_d;
  logic [3:0]      det_r;
  logic [3:0]      cls_r;
  logic [3:0]      cc_set;

  for (genvar g = 0; g < PORTS; g++) begin : g_port
    wire [1:0] mode = port_mode_i[2*g +: 2];
    wire [2:0] cres = class_result_i[3*g +: 3];
    wire       hp   = hp_enable_i[g];
    wire       mine = (prm == 2'(g));
    wire       drop = (is_off && mine) || (is_prst && mine) ||
                      (is_shed && low_prio_i[g]) ||
                      (mode == MODE_SHUTDOWN);
    wire       twr  = link.thr_wr && (link.thr_port == 2'(g));

    always_comb begin
      st_d[g]   = st_q[g];
      cnt_d[g]  = cnt_q[g];
      cut_d[g]  = cut_q[g];
      pend_d[g] = pend_q[g] || (is_on && mine);
      man_d[g]  = man_q[g];
      two_d[g]  = two_q[g];
      det_r[g]  = 1'b0;
      cls_r[g]  = 1'b0;
      cc_set[g] = 1'b0;
      if (tick && cnt_q[g] != '0) begin
        cnt_d[g] = cnt_q[g] - MS_W'(1);
      end
      case (st_q[g])
        PS_IDLE: begin
          if (mode == MODE_MANUAL && pend_q[g]) begin
            st_d[g]   = PS_CLS;
            cls_r[g]  = 1'b1;
            man_d[g]  = 1'b1;
            two_d[g]  = 1'b0;
            pend_d[g] = 1'b0;
          end else if ((mode == MODE_AUTO || mode == MODE_SEMI) &&
                       cnt_q[g] == '0) begin
            st_d[g]  = PS_DET;
            det_r[g] = 1'b1;
          end
        end
        PS_DET: begin
          if (det_done_i[g] && det_good_i[g]) begin
            st_d[g]  = PS_CLS;
            cls_r[g] = 1'b1;
            man_d[g] = 1'b0;
            two_d[g] = 1'b0;
          end else if (det_done_i[g]) begin
            st_d[g]  = PS_IDLE;
            cnt_d[g] = gap;
          end
        end
        PS_CLS: begin
          if (class_done_i[g] && cres == CLS_4 && hp && !two_q[g]) begin
            two_d[g] = 1'b1;
            cls_r[g] = 1'b1;
          end else if (class_done_i[g]) begin
            cc_set[g] = !man_q[g];
            if (man_q[g]) begin
              st_d[g]  = PS_START;
              cnt_d[g] = T_START;
            end else if (mode == MODE_AUTO && class_ok(cres)) begin
              cut_d[g] = class_cut(cres, hp);
              st_d[g]  = PS_START;
              cnt_d[g] = T_START;
            end else if (mode == MODE_SEMI && pend_q[g] &&
                         class_ok(cres)) begin
              st_d[g]   = PS_START;
              cnt_d[g]  = T_START;
              pend_d[g] = 1'b0;
            end else begin
              st_d[g]  = PS_IDLE;
              cnt_d[g] = gap;
            end
          end
        end
        PS_START: begin
          if (cnt_q[g] == '0) begin
            st_d[g]  = overload_i[g] ? PS_IDLE : PS_ON;
            cnt_d[g] = overload_i[g] ? gap : '0;
          end
        end
        PS_ON: begin
          st_d[g] = PS_ON;
        end
        default: begin
          st_d[g] = PS_IDLE;
        end
      endcase
      // Auto mode would clobber an early write, so accept it only at on
      if (twr && (mode != MODE_AUTO || st_q[g] == PS_ON)) begin
        cut_d[g] = link.thr_val;
      end
      if (drop) begin
        st_d[g]   = PS_IDLE;
        cnt_d[g]  = gap;
        pend_d[g] = 1'b0;
      end
      if (is_prst && mine) begin
        cut_d[g] = CUT_DEFAULT;
      end
    end

    always_ff @(posedge clock_i) begin
      if (srst) begin
        st_q[g]  <= PS_IDLE;
        cnt_q[g] <= '0;
        cut_q[g] <= CUT_DEFAULT;
      end else begin
        st_q[g]  <= st_d[g];
        cnt_q[g] <= cnt_d[g];
        cut_q[g] <= cut_d[g];
      end
    end

    // Outputs follow the next state so they align with the state register
    always_ff @(posedge clock_i) begin
      if (srst) begin
        power_en_o[g]        <= 1'b0;
        pgood_o[g]           <= 1'b0;
        limit_2x_o[g]        <= 1'b0;
        cut_thr_o[8*g +: 8]  <= CUT_DEFAULT;
      end else begin
        power_en_o[g]        <= (st_d[g] == PS_START) || (st_d[g] == PS_ON);
        pgood_o[g]           <= (st_d[g] == PS_ON);
        limit_2x_o[g]        <= (st_d[g] == PS_ON) && hp;
        cut_thr_o[8*g +: 8]  <= (st_d[g] == PS_START) ? CUT_START
                                                      : cut_d[g];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst) begin
      pend_q      <= 4'h0;
      man_q       <= 4'h0;
      two_q       <= 4'h0;
      det_req_o   <= 4'h0;
      class_req_o <= 4'h0;
    end else begin
      pend_q      <= pend_d;
      man_q       <= man_d;
      two_q       <= two_d;
      det_req_o   <= det_r;
      class_req_o <= cls_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events, interrupt, status

  // Low nibble: class complete; high nibble: power-good changed
  wire [3:0] pg_next;
  for (genvar h = 0; h < PORTS; h++) begin : g_pg
    assign pg_next[h] = (st_d[h] == PS_ON);
  end
  wire [7:0] evt_set = {pg_next ^ pgood_o, cc_set};
  wire [7:0] evt_clr = link.evt_rd ? evt_q : 8'h00;

  always_ff @(posedge clock_i) begin
    if (srst) begin
      evt_q <= 8'h00;
      int_q <= 1'b0;
    end else begin
      evt_q <= (evt_q & ~evt_clr) | evt_set;
      int_q <= |(evt_q & int_mask_i);
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      soft_rst_q <= 1'b0;
      midspan_q  <= 1'b0;
    end else begin
      soft_rst_q <= is_crst;
      midspan_q  <= soft_rst_q ? 1'b0 : (midspan_q ^ is_tog);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Responses, sampled in the cycle the command arrives, no filtering

  always_ff @(posedge clock_i) begin
    if (srst) begin
      resp_valid_q <= 1'b0;
      resp_data_q  <= 16'h0000;
    end else begin
      resp_valid_q <= is_vee || is_cur || link.evt_rd;
      if (is_vee) begin
        resp_data_q <= vee_mv_i;
      end else if (is_cur) begin
        resp_data_q <= port_current_i[16*prm +: 16];
      end else if (link.evt_rd) begin
        resp_data_q <= {8'h00, evt_q};
      end
    end
  end

  assign link.resp_valid = resp_valid_q;
  assign link.resp_data  = resp_data_q;
  assign link.int_req    = int_q;
  assign midspan_o       = midspan_q;
endmodule
`default_nettype wire

//--- verification/pse_link_sva.sv
// Checker for the command link between host end and port end
`default_nettype none
module pse_link_sva
  import pse_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_byte,
  input wire logic        thr_wr,
  input wire logic        evt_rd,
  input wire logic        resp_valid,
  input wire logic [15:0] resp_data,
  input wire logic        int_req
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////
  wire logic [3:0] code = cmd_byte[5:2];
  wire logic       vee  = cmd_valid && code == CMD_GET_VEE;
  wire logic       cur  = cmd_valid && code == CMD_GET_CUR;
  wire logic       chip = cmd_valid && code == CMD_CHIP_RST;
  // Chip reset swallows requests that follow it closely
  sequence s_clean;
    !$past(chip) && !$past(chip, 2);
  endsequence
  sequence s_reply;
    resp_valid;
  endsequence
  //////////////////////////////////////////////////////////////////////
  a_vee_gets_reply: assert property (vee ##0 s_clean |=> s_reply)
    else $error("no reply to supply read");
  a_cur_gets_reply: assert property (cur ##0 s_clean |=> s_reply)
    else $error("no reply to current read");
  a_evt_gets_reply: assert property (
    evt_rd ##0 s_clean |=> s_reply ##0 resp_data[15:8] == 8'h00)
    else $error("bad reply to event read");
  a_reply_has_cause: assert property (
    resp_valid |-> $past(vee || cur || evt_rd))
    else $error("reply without request");
  a_reply_held: assert property (
    !resp_valid && !$past(chip) && !$past(chip, 2) && !$past(chip, 3)
      |-> $stable(resp_data))
    else $error("reply data moved");
  a_no_overlap: assert property (!(cmd_valid && evt_rd))
    else $error("command and event read together");
  a_int_served: assert property (
    int_req |-> ##[0:16] (evt_rd || !int_req))
    else $error("interrupt left unserved");
  a_thr_silent: assert property (
    thr_wr && !cmd_valid && !evt_rd |=> !resp_valid)
    else $error("reply to threshold write");
  a_chip_quiet: assert property (chip |=> !resp_valid [*2])
    else $error("reply after chip reset");
endmodule
`default_nettype wire

//--- verification/test_pse_port_command_and_turnon_control.sv
// Bench joining host end and port end over the command link
`default_nettype none
module test_pse_port_command_and_turnon_control
  import pse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short millisecond keeps the start window at 600 cycles
  localparam int MSC = 10;
  logic        clk = 1'b0, rst = 1'b1, uv = 1'b0, tv = 1'b0;
  logic [7:0]  mode = 8'h00, tval = 8'h00;
  logic [3:0]  hp = 4'h0, lowp = 4'h0, dgood = 4'hF, uc = 4'h0;
  logic [3:0]  ddone = 4'h0, cdone = 4'h0, dreq, creq, pen, pg, l2x;
  logic [3:0]  gr = 4'h0, gm;
  logic [1:0]  up = 2'h0, tp = 2'h0;
  logic [11:0] cres = 12'h000;
  logic [63:0] cur = 64'h4444_3333_2222_1111;
  logic [15:0] vee = 16'hBEEF, rdata;
  logic [31:0] cut;
  logic        ms, urdy, rv;
  int          n_fail = 0, comparisons = 0, cyc = 0;
  int          ncls [4] = '{0, 0, 0, 0};
  //////////////////////////////////////////////////////////////////////
  pse_link_if link ();
  pse_port_ctrl #(.MS_CYCLES(MSC)) pse_port_ctrl_i (
    .clock_i(clk), .rst_i(rst), .link(link), .port_mode_i(mode),
    .hp_enable_i(hp), .low_prio_i(lowp), .int_mask_i(8'hFF),
    .det_done_i(ddone), .det_good_i(dgood), .class_done_i(cdone),
    .class_result_i(cres), .overload_i(4'h0), .port_current_i(cur),
    .vee_mv_i(vee), .det_req_o(dreq), .class_req_o(creq),
    .power_en_o(pen), .pgood_o(pg), .limit_2x_o(l2x), .cut_thr_o(cut),
    .midspan_o(ms));
  pse_host_ctrl #(.MS_CYCLES(MSC)) pse_host_ctrl_i (
    .clock_i(clk), .rst_i(rst), .link(link), .user_cmd_valid_i(uv),
    .user_code_i(uc), .user_port_i(up), .user_ready_o(urdy),
    .user_thr_valid_i(tv), .user_thr_port_i(tp), .user_thr_val_i(tval),
    .grant_i(gr), .user_resp_valid_o(rv), .user_resp_data_o(rdata),
    .events_o(), .grant_miss_o(gm));
  pse_link_sva pse_link_sva_i (
    .clock_i(clk), .rst_i(rst), .cmd_valid(link.cmd_valid),
    .cmd_byte(link.cmd_byte), .thr_wr(link.thr_wr), .evt_rd(link.evt_rd),
    .resp_valid(link.resp_valid), .resp_data(link.resp_data),
    .int_req(link.int_req));
  //////////////////////////////////////////////////////////////////////
  always #4 clk = ~clk;
  // Analog front end answers every request one cycle later
  always @(posedge clk) begin
    ddone <= dreq;
    cdone <= creq;
    for (int p = 0; p < 4; p++) if (creq[p]) ncls[p]++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      report_and_stop();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Request held until the host shows ready at a rising edge
  task automatic send(input logic [3:0] c, input logic [1:0] p);
    logic r;
    @(posedge clk);
    uv <= 1'b1;
    uc <= c;
    up <= p;
    do begin
      @(negedge clk);
      r = urdy;
      @(posedge clk);
    end while (r !== 1'b1);
    uv <= 1'b0;
  endtask
  task automatic get(output logic [15:0] d);
    int i;
    i = 0;
    do @(negedge clk); while (rv !== 1'b1 && ++i < 20);
    if (rv !== 1'b1) begin
      n_fail++;
    end
    d = rdata;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_query();
    logic [15:0] d;
    send(CMD_GET_VEE, 2'h0);
    get(d);
    chk(d, 16'hBEEF);
    send(CMD_GET_CUR, 2'h2);
    @(posedge clk);
    cur <= 64'h0;
    get(d);
    chk(d, 16'h3333);
  endtask
  task automatic t_toggle();
    send(CMD_TOGGLE_BO, 2'h0);
    tick(3);
    chk(ms, 1'b1);
    send(CMD_TOGGLE_BO, 2'h0);
    tick(3);
    chk(ms, 1'b0);
  endtask
  task automatic t_auto();
    @(posedge clk);
    mode <= 8'hFF;
    hp <= 4'b1001;
    cres <= {3'h4, 3'h6, 3'h2, 3'h1};
    tick(300);
    chk({pg, l2x}, 8'h00);
    chk(cut, 32'h7575_7575);
    tick(400);
    chk(cut, 32'hC975_351E);
    chk(l2x, 4'b1001);
    chk(pg, 4'hF);
    chk(ncls[3], 2);
    chk(ncls[0], 1);
  endtask
  task automatic t_thr();
    @(posedge clk);
    tv <= 1'b1;
    tp <= 2'h2;
    tval <= 8'h44;
    @(posedge clk);
    tv <= 1'b0;
    tick(4);
    chk(cut[23:16], 8'h44);
  endtask
  // Semi-auto keeps ports that the ops drop from powering up again
  task automatic t_ops();
    @(posedge clk);
    mode <= 8'hAA;
    lowp <= 4'b0010;
    send(CMD_SHED_LOW, 2'h0);
    tick(4);
    chk(pen, 4'b1101);
    send(CMD_PORT_RST, 2'h2);
    tick(4);
    chk({pg[2], cut[23:16]}, 9'h075);
    send(CMD_POWER_OFF, 2'h0);
    tick(4);
    chk(pen, 4'b1000);
  endtask
  task automatic t_semi();
    @(posedge clk);
    cres[8:6] <= 3'h0;
    send(CMD_POWER_ON, 2'h2);
    tick(100);
    chk(pen[2], 1'b0);
    @(posedge clk);
    cres[8:6] <= 3'h1;
    tick(60);
    chk(pen[2], 1'b1);
    tick(650);
    chk({pg[2], cut[23:16]}, 9'h175);
  endtask
  task automatic t_manual();
    @(posedge clk);
    mode[1:0] <= MODE_MANUAL;
    dgood[0] <= 1'b0;
    cres[2:0] <= 3'h7;
    // A semi-auto class cycle in flight must finish before counting
    tick(20);
    ncls[0] = 0;
    send(CMD_POWER_ON, 2'h0);
    tick(10);
    chk(pen[0], 1'b1);
    chk(ncls[0], 1);
  endtask
  task automatic t_chip();
    send(4'hF, 2'h0);
    tick(4);
    chk(pen, 4'b1101);
    send(CMD_TOGGLE_BO, 2'h0);
    send(CMD_CHIP_RST, 2'h0);
    tick(5);
    chk({ms, pen}, 5'h00);
  endtask
  // Host powers index 1 on its class event, in semi-auto mode
  task automatic t_grant();
    @(posedge clk);
    gr <= 4'b0010;
    tick(80);
    chk({gm, pen}, 8'h02);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk(cut, 32'h7575_7575);
    t_query();
    t_toggle();
    t_auto();
    t_thr();
    t_ops();
    t_semi();
    t_manual();
    t_chip();
    t_grant();
    report_and_stop();
  end
endmodule
`default_nettype wire
